// ---- core/vtp_ctrl.v ----
// video test pattern control: axi4-lite registers, pattern selection and pixel generation
// assumes one clock (pixel clock); the pixel sink drains the stream through valid and ready
//
// Function
// - Bits 7 to 4 of the control register pick the fixed pattern and reset to the white code.
// - Codes 1 to 5 give solid white, black, red, green, blue, or their complements if inverted.
// - Codes 6 to 8 give horizontal ramps from black to white, red or green, inverted from white.
// - Codes 10 to 13 give vertical ramps from black toward a colour, inverted from white.
// - Code 14 gives the programmed custom colour; codes 0 and 15 are not for software use.
// - Gradient steps are spread evenly across the active width or height.
// - With auto-scroll on, the select field is ignored for choosing the pattern.
// - Bit 3 set outputs the compliance pattern instead of the selected one.
// - Bit 2 set outputs eight vertical bars white, yellow, cyan, green, magenta, red, blue, black.
// - Bit 1 orders the four flicker bands yellow-cyan-blue-red or blue-cyan-yellow-red.
// - Bit 0 turns the generator on or off and reads 0 after reset.
// - The control register sits at byte offset 64h, is fully read-write and resets to 10h.
// - With auto-scroll on the pattern advances after a programmed frame count, else it holds.
// - Colour inversion complements every colour component; cleared, colours pass unchanged.
`default_nettype none
`include "vtp_consts.vh"

module vtp_ctrl #(
    parameter H_ACTIVE = 640,
    parameter V_ACTIVE = 480,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk,
    input wire reset_n,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output wire pix_valid,
    input wire pix_ready,
    output wire [23:0] pix_data,
    output wire pix_sof,
    output wire pix_eol
);

    localparam [11:0] H_LAST = H_ACTIVE[11:0] - 12'h001;
    localparam [11:0] V_LAST = V_ACTIVE[11:0] - 12'h001;
    localparam [15:0] H_SPAN = {4'h0, H_ACTIVE[11:0]};
    localparam [15:0] V_SPAN = {4'h0, V_ACTIVE[11:0]};

    reg [7:0] ctrl_q;
    reg [1:0] cfg_q;
    reg [23:0] custom_q;
    reg [7:0] scroll_frames_q;
    reg [3:0] scroll_idx_q;
    reg [7:0] frame_cnt_q;
    reg aw_have_q;
    reg [7:0] aw_addr_q;
    reg w_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg aw_have_d;
    reg w_have_d;
    reg bvalid_d;
    reg rvalid_d;
    reg [31:0] rdata_d;
    reg [1:0] rresp_d;
    reg [11:0] x_q;
    reg [11:0] y_q;
    reg [15:0] h_acc_q;
    reg [15:0] v_acc_q;
    reg [7:0] h_lvl_q;
    reg [7:0] v_lvl_q;
    reg [15:0] h_acc_n;
    reg [15:0] v_acc_n;
    reg [3:0] pat_code;
    reg [23:0] base_pix;
    reg [23:0] bar_pix;
    reg [23:0] band_pix;
    reg [23:0] sel_pix;
    reg [23:0] out_pix;
    wire do_wr;
    wire gen_en;
    wire invert_en;
    wire fifo_in_ready;
    wire fire;
    wire line_end;
    wire frame_end;
    wire [7:0] scroll_limit;

    assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign gen_en = ctrl_q[`VTP_BIT_GEN_EN];
    assign invert_en = cfg_q[`VTP_BIT_INVERT];
    assign fire = gen_en & fifo_in_ready;
    assign line_end = (x_q == H_LAST);
    assign frame_end = fire & line_end & (y_q == V_LAST);
    assign scroll_limit = (scroll_frames_q == 8'h00) ? 8'h01 : scroll_frames_q;

    // write channel sequencing: address and data taken in either order, response after both
    always @*
    begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        bvalid_d = s_axi_bvalid;
        if (do_wr)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
                aw_have_d = 1'b1;
            if (s_axi_wvalid & s_axi_wready)
                w_have_d = 1'b1;
            if (s_axi_bvalid & s_axi_bready)
                bvalid_d = 1'b0;
        end
    end

    // write channel registers
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VTP_RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_awready <= ~aw_have_d & ~bvalid_d;
            s_axi_wready <= ~w_have_d & ~bvalid_d;
            if (s_axi_awvalid & s_axi_awready)
                aw_addr_q <= s_axi_awaddr;
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                case ({aw_addr_q[7:2], 2'b00})
                    `VTP_OFS_CTRL, `VTP_OFS_CFG, `VTP_OFS_CUSTOM, `VTP_OFS_SCROLL,
                    `VTP_OFS_STATUS:
                        s_axi_bresp <= `VTP_RESP_OKAY;
                    default:
                        s_axi_bresp <= `VTP_RESP_SLVERR;
                endcase
            end
        end
    end

    // software registers, byte lanes honoured
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `VTP_RST_CTRL;
            cfg_q <= `VTP_RST_CFG;
            custom_q <= `VTP_RST_CUSTOM;
            scroll_frames_q <= `VTP_RST_SCROLL;
        end
        else if (do_wr)
        begin
            if (({aw_addr_q[7:2], 2'b00} == `VTP_OFS_CTRL) && w_strb_q[0])
                ctrl_q <= w_data_q[7:0];
            if (({aw_addr_q[7:2], 2'b00} == `VTP_OFS_CFG) && w_strb_q[0])
                cfg_q <= w_data_q[1:0];
            if (({aw_addr_q[7:2], 2'b00} == `VTP_OFS_SCROLL) && w_strb_q[0])
                scroll_frames_q <= w_data_q[7:0];
            if ({aw_addr_q[7:2], 2'b00} == `VTP_OFS_CUSTOM)
            begin
                if (w_strb_q[0])
                    custom_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1])
                    custom_q[15:8] <= w_data_q[15:8];
                if (w_strb_q[2])
                    custom_q[23:16] <= w_data_q[23:16];
            end
        end
    end

    // read data selection; unmapped addresses read zero with slverr
    always @*
    begin
        rdata_d = 32'h00000000;
        rresp_d = `VTP_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            `VTP_OFS_CTRL: rdata_d = {24'h000000, ctrl_q};
            `VTP_OFS_CFG: rdata_d = {30'h00000000, cfg_q};
            `VTP_OFS_CUSTOM: rdata_d = {8'h00, custom_q};
            `VTP_OFS_SCROLL: rdata_d = {24'h000000, scroll_frames_q};
            `VTP_OFS_STATUS: rdata_d = {26'h0000000, ~fifo_in_ready, gen_en, pat_code};
            default: rresp_d = `VTP_RESP_SLVERR;
        endcase
        rvalid_d = s_axi_rvalid;
        if (s_axi_arvalid & s_axi_arready)
            rvalid_d = 1'b1;
        else if (s_axi_rvalid & s_axi_rready)
            rvalid_d = 1'b0;
    end

    // read channel registers
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VTP_RESP_OKAY;
        end
        else
        begin
            s_axi_rvalid <= rvalid_d;
            s_axi_arready <= ~rvalid_d;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rresp_d;
            end
        end
    end

    // gradient accumulators: level = floor(pos * 256 / span), needs span of at least 256
    always @*
    begin
        h_acc_n = h_acc_q + `VTP_LEVELS;
        v_acc_n = v_acc_q + `VTP_LEVELS;
    end

    // raster position and even gradient stepping, halted by fifo back-pressure
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            x_q <= 12'h000;
            y_q <= 12'h000;
            h_acc_q <= 16'h0000;
            v_acc_q <= 16'h0000;
            h_lvl_q <= 8'h00;
            v_lvl_q <= 8'h00;
        end
        else if (!gen_en)
        begin
            x_q <= 12'h000;
            y_q <= 12'h000;
            h_acc_q <= 16'h0000;
            v_acc_q <= 16'h0000;
            h_lvl_q <= 8'h00;
            v_lvl_q <= 8'h00;
        end
        else if (fire)
        begin
            if (line_end)
            begin
                x_q <= 12'h000;
                h_acc_q <= 16'h0000;
                h_lvl_q <= 8'h00;
                if (y_q == V_LAST)
                begin
                    y_q <= 12'h000;
                    v_acc_q <= 16'h0000;
                    v_lvl_q <= 8'h00;
                end
                else
                begin
                    y_q <= y_q + 1'b1;
                    if (v_acc_n >= V_SPAN)
                    begin
                        v_acc_q <= v_acc_n - V_SPAN;
                        v_lvl_q <= v_lvl_q + 1'b1;
                    end
                    else
                        v_acc_q <= v_acc_n;
                end
            end
            else
            begin
                x_q <= x_q + 1'b1;
                if (h_acc_n >= H_SPAN)
                begin
                    h_acc_q <= h_acc_n - H_SPAN;
                    h_lvl_q <= h_lvl_q + 1'b1;
                end
                else
                    h_acc_q <= h_acc_n;
            end
        end
    end

    // auto-scroll: advance through codes 1 to 14 after the programmed frame count
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scroll_idx_q <= `VTP_RST_SCROLL_IDX;
            frame_cnt_q <= 8'h00;
        end
        else if (cfg_q[`VTP_BIT_ASCROLL] && frame_end)
        begin
            if (frame_cnt_q + 8'h01 >= scroll_limit)
            begin
                frame_cnt_q <= 8'h00;
                if (scroll_idx_q == `VTP_PAT_LAST)
                    scroll_idx_q <= `VTP_PAT_FIRST;
                else
                    scroll_idx_q <= scroll_idx_q + 1'b1;
            end
            else
                frame_cnt_q <= frame_cnt_q + 8'h01;
        end
    end

    // pattern colour for the current pixel
    always @*
    begin
        pat_code = cfg_q[`VTP_BIT_ASCROLL] ? scroll_idx_q : ctrl_q[`VTP_SEL_HI:`VTP_SEL_LO];
        case (h_lvl_q[7:5])
            3'h0: bar_pix = `VTP_WHITE;
            3'h1: bar_pix = `VTP_YELLOW;
            3'h2: bar_pix = `VTP_CYAN;
            3'h3: bar_pix = `VTP_GREEN;
            3'h4: bar_pix = `VTP_MAGENTA;
            3'h5: bar_pix = `VTP_RED;
            3'h6: bar_pix = `VTP_BLUE;
            default: bar_pix = `VTP_BLACK;
        endcase
        case (h_lvl_q[7:6])
            2'h0: band_pix = ctrl_q[`VTP_BIT_BAND_REV] ? `VTP_BLUE : `VTP_YELLOW;
            2'h1: band_pix = `VTP_CYAN;
            2'h2: band_pix = ctrl_q[`VTP_BIT_BAND_REV] ? `VTP_YELLOW : `VTP_BLUE;
            default: band_pix = `VTP_RED;
        endcase
        case (pat_code)
            `VTP_PAT_WHITE: base_pix = `VTP_WHITE;
            `VTP_PAT_BLACK: base_pix = `VTP_BLACK;
            `VTP_PAT_RED: base_pix = `VTP_RED;
            `VTP_PAT_GREEN: base_pix = `VTP_GREEN;
            `VTP_PAT_BLUE: base_pix = `VTP_BLUE;
            `VTP_PAT_HG_WHITE: base_pix = {h_lvl_q, h_lvl_q, h_lvl_q};
            `VTP_PAT_HG_RED: base_pix = {h_lvl_q, 16'h0000};
            `VTP_PAT_HG_GREEN: base_pix = {8'h00, h_lvl_q, 8'h00};
            `VTP_PAT_FLICKER: base_pix = band_pix;
            `VTP_PAT_VG_WHITE: base_pix = {v_lvl_q, v_lvl_q, v_lvl_q};
            `VTP_PAT_VG_RED: base_pix = {v_lvl_q, 16'h0000};
            `VTP_PAT_VG_GREEN: base_pix = {8'h00, v_lvl_q, 8'h00};
            `VTP_PAT_VG_BLUE: base_pix = {16'h0000, v_lvl_q};
            `VTP_PAT_CUSTOM: base_pix = custom_q;
            default: base_pix = `VTP_BLACK; // reserved codes show black
        endcase
        // compliance first, then bars, then the selected pattern
        if (ctrl_q[`VTP_BIT_COMPLY])
            sel_pix = (x_q[0] ^ y_q[0]) ? `VTP_BLACK : `VTP_WHITE;
        else if (ctrl_q[`VTP_BIT_BARS])
            sel_pix = bar_pix;
        else
            sel_pix = base_pix;
        out_pix = invert_en ? ~sel_pix : sel_pix;
    end

    // pixel buffer toward the video output path
    vtp_fifo #(
        .WIDTH(26),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(gen_en),
        .in_ready(fifo_in_ready),
        .in_data({(x_q == 12'h000) && (y_q == 12'h000), line_end, out_pix}),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data({pix_sof, pix_eol, pix_data})
    );

endmodule

`default_nettype wire

// ---- core/vtp_consts.vh ----
// register map, field positions, reset values and encodings of the video test pattern control
// assumes inclusion by bare name from the design files under core/
`ifndef VTP_CONSTS_VH
`define VTP_CONSTS_VH

// register byte offsets
`define VTP_OFS_CTRL 8'h64
`define VTP_OFS_CFG 8'h68
`define VTP_OFS_CUSTOM 8'h6c
`define VTP_OFS_SCROLL 8'h70
`define VTP_OFS_STATUS 8'h74

// reset values
`define VTP_RST_CTRL 8'h10
`define VTP_RST_CFG 2'h0
`define VTP_RST_CUSTOM 24'h000000
`define VTP_RST_SCROLL 8'h01
`define VTP_RST_SCROLL_IDX 4'h1

// control register fields
`define VTP_SEL_HI 7
`define VTP_SEL_LO 4
`define VTP_BIT_COMPLY 3
`define VTP_BIT_BARS 2
`define VTP_BIT_BAND_REV 1
`define VTP_BIT_GEN_EN 0

// configuration register fields
`define VTP_BIT_INVERT 1
`define VTP_BIT_ASCROLL 0

// fixed pattern select codes
`define VTP_PAT_WHITE 4'h1
`define VTP_PAT_BLACK 4'h2
`define VTP_PAT_RED 4'h3
`define VTP_PAT_GREEN 4'h4
`define VTP_PAT_BLUE 4'h5
`define VTP_PAT_HG_WHITE 4'h6
`define VTP_PAT_HG_RED 4'h7
`define VTP_PAT_HG_GREEN 4'h8
`define VTP_PAT_FLICKER 4'h9
`define VTP_PAT_VG_WHITE 4'ha
`define VTP_PAT_VG_RED 4'hb
`define VTP_PAT_VG_GREEN 4'hc
`define VTP_PAT_VG_BLUE 4'hd
`define VTP_PAT_CUSTOM 4'he
`define VTP_PAT_LAST 4'he
`define VTP_PAT_FIRST 4'h1

// gradient step and colours
`define VTP_LEVELS 16'h0100
`define VTP_WHITE 24'hffffff
`define VTP_BLACK 24'h000000
`define VTP_RED 24'hff0000
`define VTP_GREEN 24'h00ff00
`define VTP_BLUE 24'h0000ff
`define VTP_YELLOW 24'hffff00
`define VTP_CYAN 24'h00ffff
`define VTP_MAGENTA 24'hff00ff

// axi responses
`define VTP_RESP_OKAY 2'h0
`define VTP_RESP_SLVERR 2'h2

`endif

// ---- core/vtp_fifo.v ----
// synchronous fifo with valid and ready on both sides, width and depth as parameters
// assumes one clock; depth is a power of two
`default_nettype none

module vtp_fifo #(
    parameter WIDTH = 26,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    reg full_q;
    reg empty_q;
    wire push;
    wire pop;
    reg [AW:0] count_d;

    assign in_ready = ~full_q;
    assign out_valid = ~empty_q;
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & ~full_q;
    assign pop = out_ready & ~empty_q;

    // next fill level
    always @*
    begin
        count_d = count_q;
        if (push & ~pop)
            count_d = count_q + 1'b1;
        else if (pop & ~push)
            count_d = count_q - 1'b1;
    end

    // storage writes
    always @(posedge clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    // pointers and honest flags
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            count_q <= count_d;
            full_q <= (count_d == DEPTH[AW:0]);
            empty_q <= (count_d == {(AW+1){1'b0}});
        end
    end

endmodule

`default_nettype wire

// ---- test/vtp_ctrl_asserts.sv ----
// concurrent checks on the ports of the video test pattern control
// assumes binding to vtp_ctrl, one clock clk and active-low async reset_n
`default_nettype none

module vtp_ctrl_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic [23:0] pix_data,
    input wire logic pix_sof
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrote_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // remembers the first completed write
    always @(posedge clk or negedge reset_n)
        if (!reset_n)
            wrote_q <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            wrote_q <= 1'b1;

    a_gen_off_reset: assert property (!wrote_q |-> !pix_valid)
        else $error("pixels offered before any register write");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
        && (s_axi_araddr < 8'h64 || s_axi_araddr > 8'h77)
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_pix_hold: assert property (pix_valid && !pix_ready
        |=> pix_valid && $stable(pix_data) && $stable(pix_sof))
        else $error("pixel changed while stalled");
endmodule

`default_nettype wire

// ---- test/vtp_testbench.sv ----
// self-checking bench for the video test pattern control, 256x256 frame
// assumes vtp_ctrl and vtp_fifo from core/ and the checker file compiled first
`default_nettype none
`include "vtp_consts.vh"

bind vtp_ctrl vtp_ctrl_checker chk_u (.clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof));

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic awv, wv, bry, arv, rry, prdy;
    logic [7:0] awa, ara;
    logic [31:0] wd, got;
    logic [3:0] ws;
    wire logic awr, wr, bv, arr, rv, pv, sof, eol;
    wire logic [1:0] br, rr;
    wire logic [31:0] rd;
    wire logic [23:0] pd;
    integer mismatches = 0;
    integer checks = 0;
    integer i, k;
    logic [15:0] lf = 16'h0027;
    logic [23:0] cu;
    localparam logic [191:0] BARS = {`VTP_BLACK, `VTP_BLUE, `VTP_RED, `VTP_MAGENTA,
        `VTP_GREEN, `VTP_CYAN, `VTP_YELLOW, `VTP_WHITE};

    // free-running pixel clock
    always #25 clk = ~clk;

    vtp_ctrl #(.H_ACTIVE(256), .V_ACTIVE(256)) dut_u (.clk(clk), .reset_n(reset_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .pix_valid(pv), .pix_ready(prdy), .pix_data(pd),
        .pix_sof(sof), .pix_eol(eol));

    // lfsr step for repeatable random stimulus
    function logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    // expected pixel at x, y for control c, config g
    function logic [23:0] exp_px(input logic [7:0] c, input logic [1:0] g, input integer x, y);
        logic [7:0] h, v;
        logic [23:0] p;
        h = x[7:0];
        v = y[7:0];
        case (g[0] ? 4'h1 : c[7:4])
            4'h1: p = `VTP_WHITE;
            4'h2: p = `VTP_BLACK;
            4'h3: p = `VTP_RED;
            4'h4: p = `VTP_GREEN;
            4'h5: p = `VTP_BLUE;
            4'h6: p = {h, h, h};
            4'h7: p = {h, 16'h0};
            4'h8: p = {8'h0, h, 8'h0};
            4'h9: p = h[7:6] == 2'd1 ? `VTP_CYAN : h[7:6] == 2'd3 ? `VTP_RED :
                ((h[7:6] == 2'd0) ^ c[1]) ? `VTP_YELLOW : `VTP_BLUE;
            4'ha: p = {v, v, v};
            4'hb: p = {v, 16'h0};
            4'hc: p = {8'h0, v, 8'h0};
            4'hd: p = {16'h0, v};
            4'he: p = cu;
            default: p = `VTP_BLACK;
        endcase
        if (c[2])
            p = BARS[h[7:5] * 24 +: 24];
        if (c[3])
            p = (x[0] ^ y[0]) ? `VTP_BLACK : `VTP_WHITE;
        if (g[1])
            p = ~p;
        return p;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task tmo();
        mismatches++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        conclude();
    endtask

    // one write; address and data released as each is taken
    task wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        integer n;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            awv <= awv & ~awr;
            wv <= wv & ~wr;
            if (bv)
                break;
        end
        if (n == 100)
            tmo();
        check(32'(br), 32'(er));
        bry <= 1'b0;
        @(posedge clk);
    endtask

    // one read; data kept in got
    task rd_reg(input logic [7:0] a, input logic [1:0] er);
        integer n;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            arv <= arv & ~arr;
            if (rv)
                break;
        end
        if (n == 100)
            tmo();
        got = rd;
        check(32'(rr), 32'(er));
        rry <= 1'b0;
        @(posedge clk);
    endtask

    // enable a pattern, check 260 pixels under random stall, then stop and drain
    task run(input logic [7:0] c, input logic [1:0] g);
        integer n, x, y;
        x = 0;
        y = 0;
        prdy <= 1'b0; // no pixel may leave before the checking loop watches
        wr_reg(`VTP_OFS_CFG, 32'(g), 4'hf, 2'h0);
        wr_reg(`VTP_OFS_CTRL, 32'(c | 8'h01), 4'hf, 2'h0);
        for (n = 0; n < 4000 && y * 256 + x < 260; n++)
        begin
            @(negedge clk);
            if (pv && prdy)
            begin
                check(32'(pd), 32'(exp_px(c, g, x, y)));
                check(32'(sof), 32'(x == 0 && y == 0));
                check(32'(eol), 32'(x == 255));
                x = (x + 1) % 256;
                y = y + (x == 0);
            end
            @(posedge clk);
            prdy <= rnd() > 16'h6000;
        end
        if (n == 4000)
            tmo();
        wr_reg(`VTP_OFS_CTRL, 32'(c), 4'hf, 2'h0);
        prdy <= 1'b1;
        repeat (40) @(posedge clk);
        @(negedge clk);
        check(32'(pv), 32'h0);
        @(posedge clk);
        $display("test pattern %h config %h done", c, g);
    endtask

    // main sequence
    initial
    begin
        {awv, wv, bry, arv, rry, prdy} = 6'h00;
        {awa, ara, wd, ws} = 52'h0;
        cu = 24'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_reg(`VTP_OFS_CTRL, 2'h0);
        check(got, 32'h10);
        rd_reg(8'h80, `VTP_RESP_SLVERR);
        check(got, 32'h0);
        wr_reg(8'h80, 32'hffffffff, 4'hf, `VTP_RESP_SLVERR);
        for (i = 0; i < 10; i++)
        begin
            k = {16'h0, rnd()} & 32'hfe;
            wr_reg(`VTP_OFS_CTRL, k, 4'hf, 2'h0);
            rd_reg(`VTP_OFS_CTRL, 2'h0);
            check(got, k);
        end
        $display("test registers done");
        cu = {8'h3c, rnd()};
        wr_reg(`VTP_OFS_CUSTOM, 32'(cu), 4'hf, 2'h0);
        rd_reg(`VTP_OFS_CUSTOM, 2'h0);
        check(got, 32'(cu));
        run(8'h30, 2'b01);
        for (k = 0; k < 28; k++)
        begin
            i = k / 2 + 1;
            run({i[3:0], 4'h0}, {k[0], 1'b0});
        end
        run(8'h92, 2'b00);
        run(8'h34, 2'b00);
        run(8'h04, 2'b10);
        run(8'h3c, 2'b00);
        run(8'h38, 2'b10);
        conclude();
    end
endmodule

`default_nettype wire
